// file: pkg/write_guard_map.vh
`ifndef WRITE_GUARD_MAP_VH
`define WRITE_GUARD_MAP_VH
// Instruction codes (8-bit opcodes shifted in MSB first).
`define OP_WRITE_STATUS   8'h01
`define OP_WRITE_ARRAY    8'h02
`define OP_READ_ARRAY     8'h03
`define OP_CLEAR_LATCH    8'h04
`define OP_READ_STATUS    8'h05
`define OP_SET_LATCH      8'h06
// Bit counts at which chip select may rise for each instruction.
`define BITS_OPCODE       6'd8
`define BITS_STATUS_WR    6'd16
`define BITS_ADDR_END     6'd24
`define BITS_BYTE         6'd8
// Status register bit positions.
`define ST_BUSY_BIT       0
`define ST_LATCH_BIT      1
// Self-timed write duration, in ms, and its cycle count at 50 MHz.
`define WRITE_TIME_MS     5
`define CLK_HZ            50000000
`define WRITE_CYCLES      ((`CLK_HZ / 1000) * `WRITE_TIME_MS)
`define STATUS_RESET      8'h00
`endif

// file: rtl/write_timer.v
`timescale 1ns/1ps
`include "write_guard_map.vh"

module write_timer #(
  parameter WRITE_CYCLES = `WRITE_CYCLES
) (
  input  wire clk,        // System clock.
  input  wire sys_rst,    // Synchronous reset, active high.
  input  wire start,      // One-cycle pulse that launches a write.
  output wire busy        // High while the self-timed write runs.
);

  reg [23:0] count_r;
  reg        busy_r;

  // Counts the programming time; a new start while busy is ignored.
  always @(posedge clk) begin
    if (sys_rst) begin
      count_r <= 24'h000000;
      busy_r  <= 1'b0;
    end else if (busy_r) begin
      if (count_r == 24'h000001) begin
        busy_r <= 1'b0;
      end
      count_r <= count_r - 24'h000001;
    end else if (start) begin
      busy_r  <= 1'b1;
      count_r <= WRITE_CYCLES[23:0];
    end
  end

  assign busy = busy_r;

endmodule

// file: rtl/eeprom_write_guard.v
`timescale 1ns/1ps
`include "write_guard_map.vh"

module eeprom_write_guard #(
  parameter WRITE_CYCLES = `WRITE_CYCLES
) (
  input  wire       clk,            // System clock, 50 MHz.
  input  wire       sys_rst,        // Synchronous power-on reset, active high.
  input  wire       cs_n,           // Chip select pin, active low.
  input  wire       sck,            // Serial clock pin.
  input  wire       si,             // Serial data input pin.
  output reg        so_o,           // Serial data output value.
  output reg        so_oe,          // Output enable for the data pin.
  output wire       write_enable_latch,      // Latch state.
  output wire       write_in_progress_flag,  // Self-timed write running.
  output reg        array_write,    // One-cycle pulse: commit array write.
  output reg  [15:0] array_addr,    // Address of the committed write.
  output reg  [7:0] array_data,     // Last data byte of the committed write.
  output reg        status_write,   // One-cycle pulse: commit status write.
  output reg  [7:0] status_data,    // Status byte written.
  output reg        array_read,     // Pulse: fetch array byte at array_addr.
  input  wire [7:0] array_rdata     // Array byte returned for reads.
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  reg [1:0] cs_sync_r;
  reg [1:0] sck_sync_r;
  reg [1:0] si_sync_r;
  reg       sck_prev_r;
  reg       cs_prev_r;

  // Two flops on each pin; reset holds chip select as deselected.
  always @(posedge clk) begin
    if (sys_rst) begin
      cs_sync_r  <= 2'h3;
      cs_prev_r  <= 1'b1;
      sck_sync_r <= 2'h0;
      sck_prev_r <= 1'b0;
      si_sync_r  <= 2'h0;
    end else begin
      cs_sync_r  <= {cs_sync_r[0], cs_n};
      sck_sync_r <= {sck_sync_r[0], sck};
      si_sync_r  <= {si_sync_r[0], si};
      sck_prev_r <= sck_sync_r[1];
      cs_prev_r  <= cs_sync_r[1];
    end
  end

  wire sel      = ~cs_sync_r[1];
  wire sck_rise = sel & sck_sync_r[1] & ~sck_prev_r;
  wire sck_fall = sel & ~sck_sync_r[1] & sck_prev_r;
  wire cs_rise  = cs_sync_r[1] & ~cs_prev_r;
  wire cs_fall  = ~cs_sync_r[1] & cs_prev_r;

  ////////////////////////////////////////////////////////////////////////
  // Shift state.

  reg [5:0]  bit_cnt_r;
  reg [7:0]  shift_r;
  reg [7:0]  opcode_r;
  reg [15:0] addr_r;
  reg [7:0]  data_r;
  reg        wel_r;
  reg [7:0]  out_r;
  reg        reading_r;
  wire       busy;
  wire       start_write = array_write | status_write;

  // Bits arrive on rising edges, MSB first; bytes are captured in place.
  always @(posedge clk) begin
    if (sys_rst || cs_fall) begin
      bit_cnt_r <= 6'd0;
      shift_r   <= 8'h00;
      opcode_r  <= 8'h00;
      addr_r    <= 16'h0000;
      data_r    <= 8'h00;
    end else if (sck_rise) begin
      shift_r <= {shift_r[6:0], si_sync_r[1]};
      // Count saturates so an over-long frame stays distinguishable.
      if (bit_cnt_r != 6'h3F) begin
        bit_cnt_r <= bit_cnt_r + 6'd1;
      end
      if (bit_cnt_r == `BITS_OPCODE - 6'd1) begin
        opcode_r <= {shift_r[6:0], si_sync_r[1]};
      end
      if (bit_cnt_r == `BITS_OPCODE + 6'd7) begin
        addr_r[15:8] <= {shift_r[6:0], si_sync_r[1]};
      end
      if (bit_cnt_r == `BITS_STATUS_WR + 6'd7) begin
        addr_r[7:0] <= {shift_r[6:0], si_sync_r[1]};
      end
      if (bit_cnt_r >= `BITS_ADDR_END && bit_cnt_r[2:0] == 3'd7) begin
        data_r <= {shift_r[6:0], si_sync_r[1]};
      end
    end
  end

  // Frame-length checks made at the chip select rise.
  wire len_opcode = (bit_cnt_r == `BITS_OPCODE);
  wire len_status = (bit_cnt_r == `BITS_STATUS_WR);
  // A page write ends on a whole byte after at least one data byte.
  wire len_array  = (bit_cnt_r >= `BITS_ADDR_END + `BITS_BYTE) &&
                    (bit_cnt_r != 6'h3F) && (bit_cnt_r[2:0] == 3'd0);

  ////////////////////////////////////////////////////////////////////////
  // Write enable latch and write launch.

  // Commit pulses fire only on chip select rise with a valid count.
  always @(posedge clk) begin
    if (sys_rst) begin
      array_write  <= 1'b0;
      status_write <= 1'b0;
      array_addr   <= 16'h0000;
      array_data   <= 8'h00;
      status_data  <= `STATUS_RESET;
    end else begin
      array_write  <= cs_rise & ~busy & wel_r & len_array &
                      (opcode_r == `OP_WRITE_ARRAY);
      status_write <= cs_rise & ~busy & wel_r & len_status &
                      (opcode_r == `OP_WRITE_STATUS);
      if (cs_rise && !busy) begin
        array_addr  <= addr_r;
        array_data  <= data_r;
        status_data <= addr_r[15:8];
      end else if (sck_rise && !busy && bit_cnt_r == `BITS_ADDR_END - 6'd1 &&
                   opcode_r == `OP_READ_ARRAY) begin
        // A read fetch must see its own address, not the last write's.
        array_addr <= {addr_r[15:8], shift_r[6:0], si_sync_r[1]};
      end
    end
  end

  // Latch: cleared at reset and after each write launch, set only by opcode.
  always @(posedge clk) begin
    if (sys_rst) begin
      wel_r <= 1'b0;
    end else if (start_write) begin
      wel_r <= 1'b0;
    end else if (cs_rise && !busy && len_opcode) begin
      if (opcode_r == `OP_SET_LATCH) begin
        wel_r <= 1'b1;
      end else if (opcode_r == `OP_CLEAR_LATCH) begin
        wel_r <= 1'b0;
      end
    end
  end

  assign write_enable_latch = wel_r;

  write_timer #(
    .WRITE_CYCLES (WRITE_CYCLES)
  ) u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (start_write),
    .busy    (busy)
  );

  assign write_in_progress_flag = busy;

  ////////////////////////////////////////////////////////////////////////
  // Output path: status reads always, array reads only when idle.

  // Read data shifts out on falling edges, MSB first.
  always @(posedge clk) begin
    if (sys_rst || !sel) begin
      so_o       <= 1'b0;
      so_oe      <= 1'b0;
      out_r      <= 8'h00;
      reading_r  <= 1'b0;
      array_read <= 1'b0;
    end else begin
      array_read <= 1'b0;
      if (sck_fall && bit_cnt_r == `BITS_OPCODE &&
          opcode_r == `OP_READ_STATUS) begin
        reading_r <= 1'b1;
        so_oe     <= 1'b1;
        so_o      <= 1'b0;
        out_r     <= {5'h00, 1'b0, wel_r, busy} << 1;
      end else if (sck_fall && bit_cnt_r == `BITS_ADDR_END && !busy &&
                   opcode_r == `OP_READ_ARRAY) begin
        reading_r <= 1'b1;
        so_oe     <= 1'b1;
        so_o      <= array_rdata[7];
        out_r     <= {array_rdata[6:0], 1'b0};
      end else if (sck_fall && reading_r) begin
        so_o  <= out_r[7];
        out_r <= {out_r[6:0], 1'b0};
      end
      if (sck_rise && bit_cnt_r == `BITS_ADDR_END - 6'd1 && !busy &&
          opcode_r == `OP_READ_ARRAY) begin
        array_read <= 1'b1;
      end
    end
  end

endmodule

// file: bench/spi_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module spi_host_model (
  input  wire        clk,   // Bench clock.
  input  wire        so,    // Serial data from the device.
  output logic       cs_n,  // Chip select, active low.
  output logic       sck,   // Serial clock, idle low.
  output logic       si,    // Serial data to the device.
  output logic [7:0] rx     // Last eight bits read back.
);
  // Deselected and still at time zero.
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
    rx   = 8'h00;
  end
  // sends exactly n bits.
  // Half period of 8 clocks keeps sck under clk/8.
  // Data is inverted after the frame so a stale bit is never mistaken for a held one.
  task automatic frame(input logic [39:0] b, input int n);
    cs_n = 1'b0;
    repeat (8) @(negedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      si = b[i];
      repeat (8) @(negedge clk);
      sck = 1'b1;
      // The device bit is taken on the rising clock, as a mode 0 host does.
      rx  = {rx[6:0], so};
      repeat (8) @(negedge clk);
      sck = 1'b0;
    end
    repeat (8) @(negedge clk);
    cs_n = 1'b1;
    si   = ~si;
    repeat (16) @(negedge clk);
  endtask
endmodule

// file: bench/eeprom_write_guard_checker.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module eeprom_write_guard_checker #(
  parameter WRITE_CYCLES = 50
) (
  input wire clk,                     // Clock.
  input wire sys_rst,                 // Reset.
  input wire cs_n,                    // Chip select pin.
  input wire so_oe,                   // Output enable.
  input wire write_enable_latch,      // Latch.
  input wire write_in_progress_flag,  // Busy flag.
  input wire array_write,             // Array commit.
  input wire status_write             // Status commit.
);
  reg [31:0] busy_cnt_r;
  // Counts busy cycles so the full length is checked, not just a rise.
  always @(posedge clk) begin
    if (sys_rst || !write_in_progress_flag)
      busy_cnt_r <= 32'h0;
    else
      busy_cnt_r <= busy_cnt_r + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_reset_clear_latch: assert property ($fell(sys_rst) |-> !write_enable_latch)
    else $error("latch set after reset");
  a_reset_so_quiet: assert property ($fell(sys_rst) |-> !so_oe [*3])
    else $error("output driven after reset");
  a_reset_standby: assert property ($fell(sys_rst) |-> (!array_write && !status_write) [*3])
    else $error("commit right after reset");
  a_latch_after_cs: assert property ($rose(write_enable_latch) |-> cs_n && $past(cs_n, 2))
    else $error("latch set while selected");
  a_latch_not_busy: assert property ($rose(write_enable_latch) |-> !$past(write_in_progress_flag))
    else $error("latch set during write");
  a_write_needs_latch: assert property ((array_write || status_write) |-> $past(write_enable_latch))
    else $error("write without latch");
  a_write_clears_latch: assert property ((array_write || status_write) |=> !write_enable_latch)
    else $error("latch kept after write");
  a_write_starts_busy: assert property ((array_write || status_write) |=> write_in_progress_flag)
    else $error("busy flag not raised");
  a_busy_no_write: assert property (write_in_progress_flag |-> !array_write && !status_write)
    else $error("commit during busy");
  a_busy_length: assert property ($fell(write_in_progress_flag) |-> busy_cnt_r == WRITE_CYCLES)
    else $error("busy length wrong");
  a_so_off_idle: assert property (cs_n [*5] |-> !so_oe)
    else $error("output driven while deselected");
endmodule
bind eeprom_write_guard eeprom_write_guard_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
  .clk, .sys_rst, .cs_n, .so_oe, .write_enable_latch, .write_in_progress_flag,
  .array_write, .status_write);

// file: bench/eeprom_write_guard_tb_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module eeprom_write_guard_tb_top;
  localparam WC = 2000;
  typedef struct { logic [39:0] b; int n; logic [7:0] lat; int wr; } row_t;
  logic        clk, sys_rst;
  wire         cs_n, sck, si, so_o, so_oe, latch, busy, awr, swr, ard;
  wire  [15:0] addr;
  wire  [7:0]  adata, sdata, rx;
  // A released data line reads high, as through a pull-up.
  wire         so_pin = so_oe ? so_o : 1'b1;
  int          failures = 0, n_checks = 0, n_wr = 0, n_oe = 0, n_rd = 0, w0, w1;
  // Refused frames are mixed with accepted ones so a stuck latch shows.
  row_t rows[10] = '{'{40'h06, 8, 1, 0}, '{40'h02_1234_5A, 32, 0, 1},
    '{40'h02_1234_5A, 32, 0, 0}, '{40'h03, 7, 0, 0}, '{40'h0C, 9, 0, 0},
    '{40'h06, 8, 1, 0}, '{40'h01_091A_2D, 31, 1, 0}, '{40'h04, 8, 0, 0},
    '{40'h06, 8, 1, 0}, '{40'h01_3C, 16, 0, 1}};
  spi_host_model host (.clk(clk), .so(so_pin), .cs_n(cs_n), .sck(sck), .si(si), .rx(rx));
  // The array byte is a constant; only its presence on reads matters here.
  eeprom_write_guard #(.WRITE_CYCLES(WC)) uut (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
    .sck(sck), .si(si), .so_o(so_o), .so_oe(so_oe), .write_enable_latch(latch),
    .write_in_progress_flag(busy), .array_write(awr), .array_addr(addr), .array_data(adata),
    .status_write(swr), .status_data(sdata), .array_read(ard), .array_rdata(8'hA5));
  // Clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Counts commit pulses and driven output cycles.
  always @(posedge clk) begin
    if (awr === 1'b1 || swr === 1'b1) n_wr <= n_wr + 1;
    if (so_oe === 1'b1) n_oe <= n_oe + 1;
    if (ard === 1'b1) n_rd <= n_rd + 1;
  end
  task close_out;
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded wait for the self-timed write to end.
  task wait_idle;
    for (int k = 0; k < WC + 200 && busy !== 1'b0; k++) @(negedge clk);
    if (busy !== 1'b0) begin
      failures++;
      close_out;
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    for (int i = 0; i < 10; i++) begin
      w0 = n_wr;
      host.frame(rows[i].b, rows[i].n);
      check(latch, rows[i].lat);
      check(8'(n_wr - w0), 8'(rows[i].wr));
      wait_idle;
    end
    check(sdata, 8'h3C);
    // Latch and array access during a write are refused and the write runs on.
    host.frame(40'h06, 8);
    host.frame(40'h02_ABCD_C3, 32);
    check({addr[15:8]}, 8'hAB);
    check(addr[7:0], 8'hCD);
    check(adata, 8'hC3);
    check(busy, 8'h01);
    // Status stays readable while busy: latch low, busy bit high.
    host.frame(40'h05_00, 16);
    check(rx, 8'h01);
    host.frame(40'h06, 8);
    check(latch, 8'h00);
    w0 = n_oe;
    w1 = n_rd;
    host.frame(40'h03_ABCD_00, 32);
    check(8'(n_oe - w0), 8'h00);
    check(8'(n_rd - w1), 8'h00);
    check(rx, 8'hFF);
    check(busy, 8'h01);
    wait_idle;
    // An idle read fetches the addressed byte and drives it out.
    w0 = n_oe;
    host.frame(40'h03_1357_00, 32);
    check(8'(n_oe != w0), 8'h01);
    check(8'(n_rd - w1), 8'h01);
    check(addr[15:8], 8'h13);
    check(addr[7:0], 8'h57);
    check(rx, 8'hA5);
    // A frame that asks for no data leaves the output released.
    w0 = n_oe;
    host.frame(40'h06, 8);
    check(8'(n_oe - w0), 8'h00);
    host.frame(40'h05_00, 16);
    check(rx, 8'h02);
    // Reset in mid-run drops the latch and output.
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check(latch, 8'h00);
    check(so_oe, 8'h00);
    close_out;
  end
endmodule
